/* hdl/pdl_pkg.sv */
// Constants, states and carriers for the programming link physical layer
package pdl_pkg;
  // Core clock
  localparam int CLK_PERIOD_NS  = 10;
  // Window from reset release to first link clock (longest time, rounds down)
  localparam int ENA_WINDOW_US  = 100;
  localparam int ENA_WINDOW_CYC = ENA_WINDOW_US * 1000 / CLK_PERIOD_NS;
  // Inactivity threshold frequency, turned into a period in cycles
  localparam int INACT_FREQ_KHZ = 10;
  localparam int INACT_CYC      = 1000000 / INACT_FREQ_KHZ / CLK_PERIOD_NS;
  // Minimum external reset pulse width (least time, rounds up)
  localparam int RST_PULSE_NS   = 1000;
  localparam int RST_PULSE_CYC  = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Frame and character figures
  localparam int ENA_EDGES      = 16;
  localparam int DATA_BITS      = 8;
  localparam int FRAME_BITS     = 12;
  localparam int BREAK_BITS     = 12;
  localparam int GUARD_BITS     = 2;
  localparam int CNT_W          = 16;

  typedef enum logic [1:0] {ENA_OFF, ENA_ARM, ENA_ON} pdl_ena_t;
  typedef enum logic [2:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP1, RX_STOP2} pdl_rx_t;
  typedef enum logic [1:0] {TX_OFF, TX_GUARD, TX_SHIFT} pdl_tx_t;

  // Error pulses towards the controller
  typedef struct packed {
    logic parity;
    logic frame;
    logic brk;
    logic collision;
  } pdl_err_t;
endpackage : pdl_pkg

/* hdl/pdl_buf2.sv */
// Two-entry valid/ready buffer with registered outputs
`timescale 1ns/1ps
module pdl_buf2 #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic     [W-1:0]  out_data_o,
  input  wire logic         out_ready_i
);
  logic [W-1:0] skid_q;
  logic         skid_v_q;
  logic         push;
  logic         pop;

  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;

  // Head register feeds the port; skid holds the second word during a stall
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      skid_v_q    <= 1'b0;
      skid_q      <= '0;
    end else begin
      if (!out_valid_o || pop) begin
        out_valid_o <= skid_v_q | push;
        out_data_o  <= skid_v_q ? skid_q : in_data_i;
        skid_v_q    <= skid_v_q & push;
        if (skid_v_q && push) skid_q <= in_data_i;
      end else if (push) begin
        skid_v_q <= 1'b1;
        skid_q   <= in_data_i;
      end
    end
  end

  // Full only when both entries hold data
  assign in_ready_o = ~skid_v_q;
endmodule : pdl_buf2

/* hdl/pdl_phy.sv */
// Programming link physical layer: enable handshake, timeouts, serial frames
// What this block does
// [R1] Data held high beyond reset pulse width takes the reset function off the pin.
// [R2] Then sixteen rising link clock edges with data high complete enabling.
// [R3] Programmer starts the first link clock within 100 us of that release.
// [R4] Late first clock restores the pin reset function; sequence restarts.
// [R5] After sixteen edges the link is marked enabled and takes characters.
// [R6] Data pin pull-down is on exactly while the link is enabled.
// [R7] Link clock slower than about 10 kHz counts as inactivity.
// [R8] Inactivity disables the link and restores reset function unless fused off.
// [R9] Inactivity during enabling aborts it; the whole sequence starts again.
// [R10] Frame: start, eight data bits 0 to 7, parity, stop bits.
// [R11] The start bit is low.
// [R12] Detect start, frame errors, parity errors, collisions; generate transmit parity.
// [R13] Half duplex synchronous link; one driver at a time, programmer clocks both.
// [R14] The link clock enters on the reset pin.
// [R15] The test pin is the bidirectional serial data line.
// [R16] Even parity, two high stop bits ending each frame.
// [R17] Break is twelve or more low bits, idle twelve or more high; the receiver does not check for idle before a start bit.
// [R18] Senders change data on falling edges; receivers sample on rising edges.
// [R19] The layer sits in receive mode by default, waiting for a start bit.
// [R20] Inactivity is no rising edge within the threshold period of core time.
`timescale 1ns/1ps
module pdl_phy
  import pdl_pkg::*;
#(
  parameter int unsigned ENA_WIN  = ENA_WINDOW_CYC,
  parameter int unsigned INACT    = INACT_CYC
) (
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       prog_link_clock_i,
  input  wire logic       prog_link_data_i,
  output logic            prog_link_data_o,
  output logic            prog_link_data_oe_o,
  output logic            pulldown_en_o,
  input  wire logic       fuse_reset_off_i,
  output logic            reset_fn_en_o,
  output logic            link_en_o,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  input  wire logic       rx_ready_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o,
  output logic            tx_mode_o,
  output pdl_err_t        err_o
);
  localparam logic [CNT_W-1:0] WIN_LIM   = CNT_W'(ENA_WIN - 1);
  localparam logic [CNT_W-1:0] INACT_LIM = CNT_W'(INACT - 1);
  localparam logic [CNT_W-1:0] RST_LIM   = CNT_W'(RST_PULSE_CYC - 1);
  localparam logic [4:0]       EDGE_LIM  = 5'(ENA_EDGES - 1);
  localparam logic [3:0]       BRK_LIM   = 4'(BREAK_BITS - 1);
  localparam logic [3:0]       FRM_LIM   = 4'(FRAME_BITS - 1);
  localparam logic [3:0]       GRD_LIM   = 4'(GUARD_BITS - 1);
  localparam logic [2:0]       DAT_LIM   = 3'(DATA_BITS - 1);

  logic             clk_s1_q, clk_s2_q, clk_s3_q;
  logic             dat_s1_q, dat_s2_q;
  logic             fuse_s1_q, fuse_s2_q;
  logic             rise, fall;
  pdl_ena_t         ena_q;
  logic [CNT_W-1:0] hi_cnt_q, tmo_cnt_q;
  logic [4:0]       edge_cnt_q;
  logic             tmo_hit;
  pdl_rx_t          rx_q;
  logic [2:0]       rx_bit_q;
  logic [7:0]       rx_sh_q;
  logic             rx_par_q, rx_sp1_q, rx_push_q, wait_brk_q;
  logic [3:0]       brk_cnt_q;
  pdl_tx_t          tx_q;
  logic [11:0]      tx_frm_q;
  logic [3:0]       tx_cnt_q;
  logic             tx_load_q, tx_ready_q, out_bit_q, oe_q, coll;
  logic             buf_in_ready;

  // Two-flop synchronisers; third clock flop only serves edge finding
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_s1_q  <= 1'b0;
      clk_s2_q  <= 1'b0;
      clk_s3_q  <= 1'b0;
      dat_s1_q  <= 1'b0;
      dat_s2_q  <= 1'b0;
      fuse_s1_q <= 1'b0;
      fuse_s2_q <= 1'b0;
    end else begin
      clk_s1_q  <= prog_link_clock_i; // R14
      clk_s2_q  <= clk_s1_q;
      clk_s3_q  <= clk_s2_q;
      dat_s1_q  <= prog_link_data_i; // R15
      dat_s2_q  <= dat_s1_q;
      fuse_s1_q <= fuse_reset_off_i;
      fuse_s2_q <= fuse_s1_q;
    end
  end

  // Edges of the programmer clock seen by the core clock
  assign rise = clk_s2_q & ~clk_s3_q; // R18
  assign fall = ~clk_s2_q & clk_s3_q; // R18

  // Before the first edge the 100 us window applies, later the inactivity period
  assign tmo_hit = (edge_cnt_q == '0 && ena_q == ENA_ARM) ? (tmo_cnt_q >= WIN_LIM)
                                                          : (tmo_cnt_q >= INACT_LIM); // R20

  // Enable handshake and inactivity supervisor
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ena_q      <= ENA_OFF;
      hi_cnt_q   <= '0;
      tmo_cnt_q  <= '0;
      edge_cnt_q <= '0;
    end else begin
      case (ena_q)
        ENA_OFF: begin
          tmo_cnt_q  <= '0;
          edge_cnt_q <= '0;
          hi_cnt_q   <= dat_s2_q ? hi_cnt_q + 1'b1 : '0;
          if (dat_s2_q && hi_cnt_q >= RST_LIM) begin
            ena_q    <= ENA_ARM; // R1
            hi_cnt_q <= '0;
          end
        end
        ENA_ARM: begin
          tmo_cnt_q <= rise ? '0 : tmo_cnt_q + 1'b1;
          if (tmo_hit) begin
            ena_q <= ENA_OFF; // R4 R9
          end else if (rise && !dat_s2_q) begin
            ena_q <= ENA_OFF; // R2
          end else if (rise) begin
            edge_cnt_q <= edge_cnt_q + 1'b1; // R2
            if (edge_cnt_q == EDGE_LIM) ena_q <= ENA_ON; // R5
          end
        end
        ENA_ON: begin
          tmo_cnt_q <= rise ? '0 : tmo_cnt_q + 1'b1;
          if (tmo_hit) ena_q <= ENA_OFF; // R7 R8
        end
        default: ena_q <= ENA_OFF;
      endcase
    end
  end

  // Status pins; reset function returns whenever the handshake falls back and the fuse is clear
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_en_o     <= 1'b0;
      pulldown_en_o <= 1'b0;
      reset_fn_en_o <= 1'b1;
    end else begin
      link_en_o     <= (ena_q == ENA_ON); // R5
      pulldown_en_o <= (ena_q == ENA_ON); // R6
      reset_fn_en_o <= (ena_q == ENA_OFF) & ~fuse_s2_q; // R1 R4 R8
    end
  end

  // Break detector counts low bits on rising edges while receiving
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      brk_cnt_q <= '0;
    end else if (!link_en_o || tx_q != TX_OFF || dat_s2_q) begin
      if (rise || !link_en_o) brk_cnt_q <= '0;
    end else if (rise && brk_cnt_q != 4'hf) begin
      brk_cnt_q <= brk_cnt_q + 1'b1; // R17
    end
  end

  // Receiver; idles in receive mode and frames on a low start bit
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_q      <= RX_IDLE;
      rx_bit_q  <= '0;
      rx_sh_q   <= '0;
      rx_par_q  <= 1'b0;
      rx_sp1_q  <= 1'b0;
      rx_push_q <= 1'b0;
    end else begin
      rx_push_q <= 1'b0;
      if (!link_en_o || tx_q != TX_OFF) begin
        rx_q <= RX_IDLE; // R19
      end else if (rise) begin
        case (rx_q)
          RX_IDLE: begin
            // A full buffer holds off framing instead of dropping a word
            if (!dat_s2_q && buf_in_ready && !wait_brk_q) begin
              rx_q     <= RX_DATA; // R11 R12
              rx_bit_q <= '0;
            end
          end
          RX_DATA: begin
            rx_sh_q  <= {dat_s2_q, rx_sh_q[7:1]}; // R10
            rx_bit_q <= rx_bit_q + 1'b1;
            if (rx_bit_q == DAT_LIM) rx_q <= RX_PAR;
          end
          RX_PAR: begin
            rx_par_q <= dat_s2_q;
            rx_q     <= RX_STOP1;
          end
          RX_STOP1: begin
            rx_sp1_q <= dat_s2_q;
            rx_q     <= RX_STOP2;
          end
          RX_STOP2: begin
            rx_push_q <= rx_sp1_q & dat_s2_q & (rx_par_q == ^rx_sh_q); // R16
            rx_q      <= RX_IDLE;
          end
          default: rx_q <= RX_IDLE;
        endcase
      end
    end
  end

  // Error pulses; after a collision framing waits for a break
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      err_o      <= '0;
      wait_brk_q <= 1'b0;
    end else begin
      err_o.parity    <= rise & (rx_q == RX_STOP2) & (rx_par_q != ^rx_sh_q); // R12 R16
      err_o.frame     <= rise & (rx_q == RX_STOP2) & ~(rx_sp1_q & dat_s2_q); // R12 R16
      err_o.brk       <= rise & ~dat_s2_q & (brk_cnt_q == BRK_LIM) & (tx_q == TX_OFF); // R17
      err_o.collision <= coll; // R12
      if (coll) wait_brk_q <= 1'b1;
      else if (!link_en_o || err_o.brk) wait_brk_q <= 1'b0;
    end
  end

  pdl_buf2 #(.W(8)) u_rx_buf (
    .clk_i      (core_clk_i),
    .resetn_i   (resetn_i),
    .in_valid_i (rx_push_q),
    .in_data_i  (rx_sh_q),
    .in_ready_o (buf_in_ready),
    .out_valid_o(rx_valid_o),
    .out_data_o (rx_data_o),
    .out_ready_i(rx_ready_i)
  );

  // Collision: a held bit read back opposite to what we sent
  assign coll = rise & (tx_q != TX_OFF) & ~oe_q & (dat_s2_q != out_bit_q); // R12 R13

  // Transmit request port; only taken while the line is quiet in receive mode
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_ready_q <= 1'b0;
      tx_load_q  <= 1'b0;
      tx_frm_q   <= '1;
    end else begin
      tx_ready_q <= link_en_o & (tx_q == TX_OFF) & (rx_q == RX_IDLE) & ~wait_brk_q
                    & ~tx_load_q & ~(tx_valid_i & tx_ready_q);
      if (tx_valid_i && tx_ready_q) begin
        tx_load_q <= 1'b1;
        tx_frm_q  <= {2'b11, ^tx_data_i, tx_data_i, 1'b0}; // R10 R11 R16
      end else if (tx_q != TX_OFF || !link_en_o) begin
        tx_load_q <= 1'b0;
      end
    end
  end
  assign tx_ready_o = tx_ready_q;

  // Transmitter: guard idles, then frame bits, changed on falling edges
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_q      <= TX_OFF;
      tx_cnt_q  <= '0;
      out_bit_q <= 1'b1;
      oe_q      <= 1'b0;
    end else if (!link_en_o || coll) begin
      tx_q <= TX_OFF; // R12 R13
      oe_q <= 1'b0;
    end else if (fall) begin
      case (tx_q)
        TX_OFF: begin
          if (tx_load_q) begin
            tx_q      <= TX_GUARD;
            tx_cnt_q  <= '0;
            out_bit_q <= 1'b1;
            oe_q      <= 1'b1; // R13
          end
        end
        TX_GUARD: begin
          tx_cnt_q <= tx_cnt_q + 1'b1;
          oe_q     <= 1'b0;
          if (tx_cnt_q == GRD_LIM) begin
            tx_q      <= TX_SHIFT;
            tx_cnt_q  <= '0;
            out_bit_q <= tx_frm_q[0];
            oe_q      <= ~tx_frm_q[0]; // R18
          end
        end
        TX_SHIFT: begin
          // Driver only on a change; the keeper holds repeats so they can be checked
          if (tx_cnt_q == FRM_LIM) begin
            tx_q <= TX_OFF; // R19
            oe_q <= 1'b0;
          end else begin
            tx_cnt_q  <= tx_cnt_q + 1'b1;
            out_bit_q <= tx_frm_q[tx_cnt_q + 4'h1];
            oe_q      <= tx_frm_q[tx_cnt_q + 4'h1] != out_bit_q; // R18
          end
        end
        default: tx_q <= TX_OFF;
      endcase
    end
  end

  // Pin drive and mode straight from flops
  assign prog_link_data_o    = out_bit_q;
  assign prog_link_data_oe_o = oe_q;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) tx_mode_o <= 1'b0;
    else tx_mode_o <= (tx_q != TX_OFF);
  end

  // Checks
  property p_en_on_edge;
    @(posedge core_clk_i) disable iff (!resetn_i)
      $rose(link_en_o) |-> $past(rise, 2) && $past(edge_cnt_q, 2) == EDGE_LIM;
  endproperty
  a_en_on_edge: assert property (p_en_on_edge) else $error("enable without 16th edge"); // R5

  property p_pulldown;
    @(posedge core_clk_i) disable iff (!resetn_i)
      pulldown_en_o == link_en_o;
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down not tracking enable"); // R6

  property p_arm_tmo;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (ena_q == ENA_ARM && tmo_hit) |=> ena_q == ENA_OFF ##1 reset_fn_en_o == !fuse_s2_q;
  endproperty
  a_arm_tmo: assert property (p_arm_tmo) else $error("late first clock not rejected"); // R4

  property p_inact;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (ena_q == ENA_ON && !rise && tmo_cnt_q >= INACT_LIM) |=> ##1 !link_en_o;
  endproperty
  a_inact: assert property (p_inact) else $error("inactivity did not disable"); // R8

  property p_arm_no_reset;
    @(posedge core_clk_i) disable iff (!resetn_i)
      ena_q == ENA_ARM |=> !reset_fn_en_o;
  endproperty
  a_arm_no_reset: assert property (p_arm_no_reset) else $error("reset function active"); // R1

  property p_frame_fmt;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (tx_valid_i && tx_ready_q) |=>
        tx_frm_q[11:10] == 2'b11 && !tx_frm_q[0] && tx_frm_q[9] == ^tx_frm_q[8:1];
  endproperty
  a_frame_fmt: assert property (p_frame_fmt) else $error("bad transmit frame"); // R16

  property p_coll;
    @(posedge core_clk_i) disable iff (!resetn_i)
      coll |=> tx_q == TX_OFF && !oe_q && err_o.collision;
  endproperty
  a_coll: assert property (p_coll) else $error("collision not handled"); // R12

  property p_change_on_fall;
    @(posedge core_clk_i) disable iff (!resetn_i)
      $changed(out_bit_q) |-> $past(fall);
  endproperty
  a_change_on_fall: assert property (p_change_on_fall) else $error("data changed off fall"); // R18

  c_enable: cover property (@(posedge core_clk_i) disable iff (!resetn_i) $rose(link_en_o));
  c_rx_word: cover property (@(posedge core_clk_i) disable iff (!resetn_i) rx_push_q);
  c_tx_done: cover property (@(posedge core_clk_i) disable iff (!resetn_i) $fell(tx_mode_o));
  c_break: cover property (@(posedge core_clk_i) disable iff (!resetn_i) err_o.brk);
endmodule : pdl_phy

/* verification/pdl_prog_model.sv */
// Programmer model: link clock, data pin driving and frame capture
`timescale 1ns/1ps
module pdl_prog_model (
  output logic      link_clk_o,
  output logic      data_o,
  output logic      data_oe_o,
  input  wire logic line_i
);
  // Link clock stands still low between bursts
  initial begin
    link_clk_o = 1'b0;
    data_o     = 1'b0;
    data_oe_o  = 1'b0;
  end

  // Hold the data pin at a level without clocking
  task automatic drive(input logic v);
    data_oe_o = 1'b1;
    data_o    = v;
  endtask : drive

  // One bit time: change after falling edge, sample at rising edge
  task automatic tick(input logic v, input logic drv, output logic s);
    data_oe_o = drv;
    data_o    = v;
    #40 link_clk_o = 1'b1;
    s = line_i;
    #40 link_clk_o = 1'b0;
  endtask : tick

  // Idle bits, also the sixteen enabling cycles
  task automatic idle(input int n);
    logic s;
    repeat (n) tick(1'b1, 1'b1, s);
  endtask : idle

  // Whole frame; pf spoils parity, sb pulls stop bit 1 low
  task automatic send(input logic [7:0] d, input logic pf, input logic sb);
    logic [11:0] f;
    logic        s;
    f = {1'b1, ~sb, ^d ^ pf, d, 1'b0};
    for (int i = 0; i < 12; i++) tick(f[i], 1'b1, s);
  endtask : send

  // Exactly twelve low bits, then back to idle
  task automatic brk();
    logic s;
    repeat (12) tick(1'b0, 1'b1, s);
    idle(1);
  endtask : brk

  // Capture a device frame; col fights both stop bits low
  task automatic grab(input logic col, output logic [11:0] f);
    logic s;
    f = '1;
    s = 1'b1;
    for (int i = 0; i < 40 && s; i++) tick(1'b1, 1'b0, s);
    f[0] = s;
    for (int i = 1; i < 12; i++) tick(1'b0, col && i > 9, f[i]);
  endtask : grab
endmodule : pdl_prog_model

/* verification/pdl_phy_tb.sv */
// Self-checking bench for the programming link physical layer
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
  $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module pdl_phy_tb;
  import pdl_pkg::*;
  localparam int ENA_WIN_T = 400;
  localparam int INACT_T   = 300;
  logic        core_clk_i, resetn_i, link_clk, prog_d, prog_oe, line;
  logic        dut_d, dut_oe, pulldown_en, reset_fn_en, link_en;
  logic        rx_valid, rx_ready, tx_valid, tx_ready, tx_mode, err_clr, fuse;
  logic [7:0]  rx_data, tx_data, exp_b;
  logic [11:0] fr;
  logic [31:0] rnd;
  pdl_err_t    err, err_seen;
  logic [7:0]  rxq[$];
  int          failures, check_count;

  pdl_phy #(.ENA_WIN(ENA_WIN_T), .INACT(INACT_T)) u_dut (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .prog_link_clock_i(link_clk),
    .prog_link_data_i(line), .prog_link_data_o(dut_d), .prog_link_data_oe_o(dut_oe),
    .pulldown_en_o(pulldown_en), .fuse_reset_off_i(fuse), .reset_fn_en_o(reset_fn_en),
    .link_en_o(link_en), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_ready_i(rx_ready),
    .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
    .tx_mode_o(tx_mode), .err_o(err));

  pdl_prog_model u_prog (.link_clk_o(link_clk), .data_o(prog_d), .data_oe_o(prog_oe),
    .line_i(line));

  // Core clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Bus keeper: pin keeps its last level; starts low so the first rise is real
  initial line = 1'b0;
  always @* begin
    if (dut_oe === 1'b1) line = dut_d;
    else if (prog_oe === 1'b1) line = prog_d;
  end

  // Monitor: error pulses gathered, received words matched against notes
  always @(posedge core_clk_i) begin
    if (err_clr) err_seen <= '0;
    else err_seen <= err_seen | err;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      `CHK(rxq.size() > 0, 1'b1)
      if (rxq.size() > 0) begin
        exp_b = rxq.pop_front();
        `CHK(rx_data, exp_b)
      end
    end
  end

  // Fixed-seed pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc

  task automatic eclr();
    err_clr = 1'b1;
    cyc(1);
    err_clr = 1'b0;
  endtask : eclr

  // Offer one word; held until the edge that sees ready high
  task automatic send_tx(input logic [7:0] d);
    int n;
    tx_data  = d;
    tx_valid = 1'b1;
    n = 0;
    @(negedge core_clk_i);
    while (tx_ready !== 1'b1 && n < 100) begin
      n++;
      @(negedge core_clk_i);
    end
    `CHK(tx_ready, 1'b1)
    if (n >= 100) wrap_up();
    @(posedge core_clk_i);
    #1 tx_valid = 1'b0;
  endtask : send_tx

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Hang guard
  initial begin
    #200us;
    failures++;
    $display("Error at %0t: got %0h expected %0h", $time, 0, 1);
    wrap_up();
  end

  initial begin
    resetn_i = 1'b0;
    rx_ready = 1'b0;
    tx_valid = 1'b0;
    tx_data  = 8'h00;
    err_clr  = 1'b1;
    fuse     = 1'b0;
    rnd      = 32'he2807fb3;
    failures = 0;
    check_count = 0;
    repeat (4) @(posedge core_clk_i);
    #1 resetn_i = 1'b1;
    err_clr = 1'b0;
    cyc(1);
    `CHK({reset_fn_en, link_en, pulldown_en, dut_oe, tx_mode}, 5'b10000)
    $display("Test reset done");
    // First link clock never comes: pin reset function returns
    u_prog.drive(1'b1);
    cyc(90);
    `CHK(reset_fn_en, 1'b1)
    cyc(20);
    `CHK(reset_fn_en, 1'b0)
    cyc(ENA_WIN_T + 30);
    `CHK({reset_fn_en, link_en}, 2'b10)
    u_prog.drive(1'b0);
    cyc(20);
    $display("Test late clock done");
    // Clock stops partway through enabling
    u_prog.drive(1'b1);
    cyc(110);
    u_prog.idle(5);
    cyc(INACT_T + 20);
    `CHK({reset_fn_en, link_en}, 2'b10)
    // Data low at a link edge while enabling aborts it as well
    cyc(110);
    u_prog.idle(3);
    u_prog.brk();
    `CHK({reset_fn_en, link_en}, 2'b10)
    u_prog.drive(1'b0);
    cyc(20);
    $display("Test aborted enable done");
    // Full enable; fifteen edges are not enough
    u_prog.drive(1'b1);
    cyc(110);
    u_prog.idle(15);
    cyc(6);
    `CHK(link_en, 1'b0)
    u_prog.idle(1);
    cyc(10);
    `CHK({link_en, pulldown_en, reset_fn_en, tx_mode, dut_oe}, 5'b11000)
    $display("Test enable done");
    // Two words while stalled, drain, then two more back to back
    eclr();
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      rxq.push_back(rnd[7:0]);
      u_prog.send(rnd[7:0], 1'b0, 1'b0);
      if (k == 1) begin
        u_prog.idle(2);
        `CHK(rx_valid, 1'b1)
        rx_ready = 1'b1;
      end
    end
    u_prog.idle(3);
    `CHK(rxq.size(), 0)
    `CHK(err_seen, 4'b0000)
    $display("Test receive done");
    // Bad parity, bad stop bit, then a break
    eclr();
    u_prog.send(8'h5a, 1'b1, 1'b0);
    u_prog.idle(3);
    `CHK(err_seen, 4'b1000)
    eclr();
    u_prog.send(8'h3c, 1'b0, 1'b1);
    u_prog.idle(3);
    `CHK(err_seen, 4'b0100)
    eclr();
    u_prog.brk();
    u_prog.idle(3);
    `CHK(err_seen, 4'b0110)
    $display("Test receive errors done");
    // Transmit a random word and read the whole frame off the pin
    rnd = lfsr(rnd);
    send_tx(rnd[7:0]);
    u_prog.grab(1'b0, fr);
    `CHK(fr, {2'b11, ^rnd[7:0], rnd[7:0], 1'b0})
    if (fr[0] !== 1'b0) wrap_up();
    cyc(4);
    `CHK({tx_mode, dut_oe}, 2'b00)
    // Programmer fights the held stop bit; recovery by break
    eclr();
    send_tx(8'h01);
    u_prog.grab(1'b1, fr);
    `CHK(fr[0], 1'b0)
    if (fr[0] !== 1'b0) wrap_up();
    u_prog.idle(2);
    `CHK(err_seen.collision, 1'b1)
    eclr();
    u_prog.brk();
    u_prog.idle(3);
    `CHK(err_seen.brk, 1'b1)
    $display("Test transmit done");
    // Clock stops with the fuse set: link drops, pin reset stays off
    fuse = 1'b1;
    cyc(INACT_T - 60);
    `CHK(link_en, 1'b1)
    cyc(80);
    `CHK({link_en, pulldown_en, reset_fn_en}, 3'b000)
    // Fuse released: pin reset function comes back
    fuse = 1'b0;
    cyc(5);
    `CHK(reset_fn_en, 1'b1)
    $display("Test inactivity done");
    wrap_up();
  end
endmodule : pdl_phy_tb
